// File: dv/tks_port_ctrl_tb_top.sv
// self-checking bench for the token port controller
module tks_port_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    reg core_clk = 0, nrst = 0, cmd_valid = 0;
    reg [1:0] cmd_op = 0;
    reg [2:0] cmd_idx = 0, r_idx = 0;
    reg r_sel_n = 1, r_oe_n = 1, r_wr_n = 1, r_d0 = 1;
    wire ready, done, granted, init_done, ce_n, sel_n, oe_n, wr_n, dq_oe_n;
    wire [7:0] held, dq_out, dq_in, r_q;
    wire [13:0] addr;
    integer errors = 0, tests_run = 0, cyc = 0, i;
    reg [7:0] rq; // last right-side read
    // row: right write, its value, op, token, granted, right flag
    reg [8:0] rows [0:6];
    tks_port_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_idx(cmd_idx), .cmd_ready_q(ready), .done_q(done),
        .granted_q(granted), .held_q(held), .init_done_q(init_done), .mem_en_n_q(ce_n),
        .token_select_n_q(sel_n), .out_en_n_q(oe_n), .wr_n_q(wr_n), .addr_q(addr),
        .dq_out_q(dq_out), .dq_oe_n_q(dq_oe_n), .dq_in(dq_in));
    tks_sem_model u_dev (.l_sel_n(sel_n), .l_oe_n(oe_n), .l_wr_n(wr_n), .l_ce_n(ce_n),
        .l_addr(addr), .l_d(dq_out), .l_q(dq_in), .r_sel_n(r_sel_n), .r_oe_n(r_oe_n),
        .r_wr_n(r_wr_n), .r_idx(r_idx), .r_d0(r_d0), .r_q(r_q));
    // clock and hang guard; the longest run is well under this ceiling
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            summarize;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // offer one command, hold it until taken, then wait for done
    task cmd(input [1:0] op, input [2:0] idx);
        begin
            @(posedge core_clk) #1;
            {cmd_op, cmd_idx, cmd_valid} = {op, idx, 1'b1};
            @(posedge core_clk);
            while (ready !== 1'b1) @(posedge core_clk);
            #1 cmd_valid = 0;
            while (done !== 1'b1) @(posedge core_clk) #1;
            @(posedge core_clk) #1;
        end
    endtask
    // right-side cycle of two clocks: write when wr is set, else read
    task rpin(input wr, input [2:0] idx, input d);
        begin
            @(posedge core_clk) #1;
            {r_idx, r_d0, r_sel_n, r_wr_n, r_oe_n} = {idx, d, 1'b0, !wr, wr};
            repeat (2) @(posedge core_clk);
            rq = r_q;
            #1 {r_sel_n, r_wr_n, r_oe_n} = 3'h7;
        end
    endtask
    task summarize;
        begin
            if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        rows[0] = 9'b0_0_00_000_1_1; // free claim wins, right sees one
        rows[1] = 9'b1_0_10_000_1_1; // right asks, still ours
        rows[2] = 9'b0_0_01_000_0_0; // release hands over to right
        rows[3] = 9'b0_0_00_000_0_0; // claim on held token fails
        rows[4] = 9'b1_1_10_000_0_1; // right frees; our request was withdrawn
        rows[5] = 9'b0_0_00_111_1_1; // top index
        rows[6] = 9'b0_0_01_111_0_1;
        repeat (12) @(posedge core_clk);
        #1 nrst = 1;
        for (i = 0; i < 8; i = i + 1) rpin(1, i[2:0], 1'b1);
        while (init_done !== 1'b1) @(posedge core_clk);
        for (i = 0; i < 7; i = i + 1) begin
            if (rows[i][8]) rpin(1, rows[i][4:2], rows[i][7]);
            cmd(rows[i][6:5], rows[i][4:2]);
            chk(granted, rows[i][1]);
            chk(held[rows[i][4:2]], rows[i][1]);
            rpin(0, rows[i][4:2], 1'b1);
            chk(rq, {8{rows[i][0]}});
        end
        // reset in mid-run parks every strobe and blocks commands
        @(posedge core_clk) #1 nrst = 0;
        repeat (2) @(posedge core_clk);
        #1 chk({sel_n, wr_n, oe_n, dq_oe_n, ready, ce_n}, 8'h3D);
        nrst = 1;
        while (init_done !== 1'b1) @(posedge core_clk);
        cmd(2'h0, 3'h5);
        chk(granted, 8'h01);
        summarize;
    end
endmodule // tks_port_ctrl_tb_top

// File: dv/tks_sem_model.sv
// behavioural token device: left port on controller pins, right port from the bench
module tks_sem_model (
    input wire l_sel_n,
    input wire l_oe_n,
    input wire l_wr_n,
    input wire l_ce_n,
    input wire [13:0] l_addr,
    input wire [7:0] l_d,
    output wire [7:0] l_q,
    input wire r_sel_n,
    input wire r_oe_n,
    input wire r_wr_n,
    input wire [2:0] r_idx,
    input wire r_d0,
    output wire [7:0] r_q
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] req_l; // eight left request latches, never reset
    reg [7:0] req_r; // eight right request latches, never reset
    reg [7:0] first; // one bit per token, so only one side can win
    reg [2:0] li, ri; // token index held during a write
    reg ld, rd; // written bit held during a write
    reg [7:0] lo, ro; // read latches of each side
    wire lw = !l_sel_n && !l_wr_n && l_ce_n; // token space only with memory off
    wire lr = !l_sel_n && !l_oe_n && l_ce_n;
    wire rw = !r_sel_n && !r_wr_n;
    wire rr = !r_sel_n && !r_oe_n;
    wire [7:0] own_l = ~req_l & (req_r | ~first);
    wire [7:0] own_r = ~req_r & (req_l | first);
    // keep index and bit 0 only; the bus may move as the strobe ends
    always @* if (lw) begin li = l_addr[2:0]; ld = l_d[0]; end
    always @* if (rw) begin ri = r_idx; rd = r_d0; end
    // commit at strobe end; release hands over to a pending side
    always @(negedge lw) begin
        req_l[li] <= ld;
        if (ld || req_r[li] !== 1'b0) first[li] <= ld;
    end
    // right commits a moment later, so an exact tie goes to the left port
    always @(negedge rw) begin
        #1;
        req_r[ri] <= rd;
        if (rd || req_l[ri] !== 1'b0) first[ri] <= !rd;
    end
    // flag spread over all bits, frozen while select and oe stay low
    always @(posedge lr) lo <= {8{~own_l[l_addr[2:0]]}};
    always @(posedge rr) ro <= {8{~own_r[r_idx]}};
    // a released bus shows the inverse so a stale value never passes
    assign l_q = lr ? lo : ~lo;
    assign r_q = rr ? ro : ~ro;
endmodule // tks_sem_model

// File: dv/tks_sva.sv
// pin-level assertions for the token port controller
module tks_sva (
    input wire core_clk,
    input wire nrst,
    input wire mem_en_n_q,
    input wire token_select_n_q,
    input wire out_en_n_q,
    input wire wr_n_q,
    input wire [13:0] addr_q,
    input wire [7:0] dq_out_q,
    input wire dq_oe_n_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // start of a zero write, the first step of a claim
    sequence s_wr0;
        $fell(wr_n_q) && !dq_out_q[0];
    endsequence
    // start of a read strobe
    sequence s_rd;
        $fell(out_en_n_q);
    endsequence
    a_mem_en_off: assert property (mem_en_n_q)
        else $error("memory enable active");
    a_upper_addr: assert property (!token_select_n_q |-> addr_q[13:3] == 11'h000)
        else $error("upper address not zero");
    a_data_high: assert property (!dq_oe_n_q |-> dq_out_q[7:1] == 7'h7F)
        else $error("upper data bits not high");
    a_write_sel: assert property (!wr_n_q |-> !token_select_n_q && !dq_oe_n_q)
        else $error("write without select or data");
    a_read_sel: assert property (!out_en_n_q |-> !token_select_n_q && wr_n_q && dq_oe_n_q)
        else $error("read strobe malformed");
    // one-cycle read strobe, released at once so the next read re-latches
    a_read_gap: assert property (s_rd |=> out_en_n_q)
        else $error("read strobe not released");
    a_claim_read: assert property (s_wr0 |-> ##[2:5] s_rd)
        else $error("zero write not read back");
    // one-cycle write strobe: a 100 ns clock already meets the least width
    a_wr_width: assert property ($fell(wr_n_q) |=> wr_n_q)
        else $error("write strobe width");
endmodule // tks_sva
bind tks_port_ctrl tks_sva u_sva (.core_clk(core_clk), .nrst(nrst), .mem_en_n_q(mem_en_n_q),
    .token_select_n_q(token_select_n_q), .out_en_n_q(out_en_n_q), .wr_n_q(wr_n_q),
    .addr_q(addr_q), .dq_out_q(dq_out_q), .dq_oe_n_q(dq_oe_n_q));

// File: hdl/tks_held_mem.v
// small register of which tokens this port believes it holds
module tks_held_mem #(
    parameter N = 8,
    parameter IW = 3
) (
    input wire core_clk,
    input wire nrst,
    input wire wr_en,
    input wire [IW-1:0] wr_idx,
    input wire wr_val,
    output wire [N-1:0] held_q
);
    // one flop per token, cleared at reset since the controller starts owning nothing
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_tok
            reg bit_q; // held flag of this token, own flop so each bit has one driver
            always @(posedge core_clk) begin
                if (!nrst) begin
                    bit_q <= 1'b0;
                end else if (wr_en && wr_idx == g) begin
                    bit_q <= wr_val;
                end
            end
            assign held_q[g] = bit_q;
        end
    endgenerate
endmodule // tks_held_mem

// File: hdl/tks_map.vh
// constants for the token semaphore port controller
`ifndef TKS_MAP_VH
`define TKS_MAP_VH
`define TKS_NUM_TOKENS 8
`define TKS_IDX_W 3
`define TKS_ADDR_W 14
`define TKS_DATA_W 8
// pin timing: least strobe width and clock period in ns, at 10 MHz core_clk
`define TKS_CLK_NS 100
`define TKS_STROBE_NS 100
`define TKS_STROBE_CYC ((`TKS_STROBE_NS + `TKS_CLK_NS - 1) / `TKS_CLK_NS)
`define TKS_IDLE_DATA 8'hFF
`endif

// File: hdl/tks_port_ctrl.v
// one-port controller that claims, polls and releases the dual-port semaphore tokens
// Behaviour
// - token select low, then ordinary sram cycle
// - deassert select or oe between reads
// - claim by write zero then read back
// - after failed claim, poll or withdraw
// - software writes one to all at start
// - memory chip enable high during token access
`include "tks_map.vh"
module tks_port_ctrl #(
    parameter RETRIES = 4'h4
) (
    input wire core_clk,
    input wire nrst,
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [`TKS_IDX_W-1:0] cmd_idx,
    output reg cmd_ready_q,
    output reg done_q,
    output reg granted_q,
    output reg [`TKS_NUM_TOKENS-1:0] held_q,
    output reg init_done_q,
    output reg mem_en_n_q,
    output reg token_select_n_q,
    output reg out_en_n_q,
    output reg wr_n_q,
    output reg [`TKS_ADDR_W-1:0] addr_q,
    output reg [`TKS_DATA_W-1:0] dq_out_q,
    output reg dq_oe_n_q,
    input wire [`TKS_DATA_W-1:0] dq_in
);
    // command codes: claim, release, read status
    localparam OP_CLAIM = 2'h0;
    localparam OP_RELEASE = 2'h1;
    localparam OP_READ = 2'h2;
    // one-hot states
    localparam S_INIT = 7'h01;
    localparam S_IDLE = 7'h02;
    localparam S_WR = 7'h04;
    localparam S_GAP = 7'h08;
    localparam S_RD = 7'h10;
    localparam S_DONE = 7'h20;
    localparam S_WAIT = 7'h40;
    localparam integer STROBE_I = `TKS_STROBE_CYC; // whole strobe count
    localparam [3:0] STROBE = STROBE_I[3:0]; // cut to the counter width on purpose

    reg [6:0] st_q; // current state
    reg [3:0] cnt_q; // strobe width counter
    reg [`TKS_IDX_W-1:0] idx_q; // token in progress
    reg [1:0] op_q; // command in progress
    reg wval_q; // value written on bit zero
    reg [3:0] try_q; // polls left after a failed claim
    reg init_q; // init sweep active
    reg mem_wr_q; // pulse to update held map
    reg mem_val_q; // value to store in held map
    wire [`TKS_NUM_TOKENS-1:0] held_w; // held map from memory
    wire rd_zero; // sampled flag low on all bits

    // held-token register lives in its own small module
    tks_held_mem #(
        .N(`TKS_NUM_TOKENS),
        .IW(`TKS_IDX_W)
    ) u_mem (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(mem_wr_q),
        .wr_idx(idx_q),
        .wr_val(mem_val_q),
        .held_q(held_w)
    );

    // flag is replicated on every bit; trust it only when it is all zeros
    assign rd_zero = (dq_in == {`TKS_DATA_W{1'b0}});

    // main sequencer: every token access is a plain sram write or read
    always @(posedge core_clk) begin
        if (!nrst) begin
            st_q <= S_INIT;
            cnt_q <= 4'h0;
            idx_q <= {`TKS_IDX_W{1'b0}};
            op_q <= OP_RELEASE;
            wval_q <= 1'b1;
            try_q <= 4'h0;
            init_q <= 1'b1;
            mem_wr_q <= 1'b0;
            mem_val_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            done_q <= 1'b0;
            granted_q <= 1'b0;
            init_done_q <= 1'b0;
            mem_en_n_q <= 1'b1;
            token_select_n_q <= 1'b1;
            out_en_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            addr_q <= {`TKS_ADDR_W{1'b0}};
            dq_out_q <= `TKS_IDLE_DATA;
            dq_oe_n_q <= 1'b1;
        end else begin
            mem_wr_q <= 1'b0;
            done_q <= 1'b0;
            mem_en_n_q <= 1'b1;
            case (st_q)
                S_INIT: begin
                    // latches power up unknown: free each one from this side
                    op_q <= OP_RELEASE;
                    wval_q <= 1'b1;
                    cnt_q <= 4'h0;
                    st_q <= S_WR;
                end
                S_IDLE: begin
                    token_select_n_q <= 1'b1;
                    out_en_n_q <= 1'b1;
                    wr_n_q <= 1'b1;
                    dq_oe_n_q <= 1'b1;
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        idx_q <= cmd_idx;
                        // address settles before any strobe falls, so a read latches the right flag
                        addr_q <= {{(`TKS_ADDR_W-`TKS_IDX_W){1'b0}}, cmd_idx};
                        op_q <= cmd_op;
                        wval_q <= (cmd_op != OP_CLAIM);
                        try_q <= RETRIES;
                        cnt_q <= 4'h0;
                        st_q <= (cmd_op == OP_READ) ? S_GAP : S_WR;
                    end
                end
                S_WR: begin
                    // select low, write strobe low, bit zero carries value
                    token_select_n_q <= 1'b0;
                    wr_n_q <= 1'b0;
                    out_en_n_q <= 1'b1;
                    addr_q <= {{(`TKS_ADDR_W-`TKS_IDX_W){1'b0}}, idx_q};
                    dq_out_q <= {{(`TKS_DATA_W-1){1'b1}}, wval_q};
                    dq_oe_n_q <= 1'b0;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == STROBE) begin
                        wr_n_q <= 1'b1;
                        st_q <= S_GAP;
                        cnt_q <= 4'h0;
                    end
                end
                S_GAP: begin
                    // both strobes high so the next read re-latches the flag
                    token_select_n_q <= 1'b1;
                    out_en_n_q <= 1'b1;
                    wr_n_q <= 1'b1;
                    dq_oe_n_q <= 1'b1;
                    cnt_q <= 4'h0;
                    if (init_q || op_q == OP_RELEASE) begin
                        mem_wr_q <= 1'b1;
                        mem_val_q <= 1'b0;
                        st_q <= S_DONE;
                    end else begin
                        st_q <= S_RD;
                    end
                end
                S_RD: begin
                    token_select_n_q <= 1'b0;
                    out_en_n_q <= 1'b0;
                    addr_q <= {{(`TKS_ADDR_W-`TKS_IDX_W){1'b0}}, idx_q};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == STROBE) begin
                        // sample at end of strobe; device holds it stable till now
                        granted_q <= rd_zero;
                        mem_wr_q <= 1'b1;
                        mem_val_q <= rd_zero;
                        token_select_n_q <= 1'b1;
                        out_en_n_q <= 1'b1;
                        cnt_q <= 4'h0;
                        if (op_q == OP_CLAIM && !rd_zero && try_q != 4'h0) begin
                            // request still latched on the far side; poll again
                            try_q <= try_q - 4'h1;
                            st_q <= S_WAIT;
                        end else if (op_q == OP_CLAIM && !rd_zero) begin
                            // give up and withdraw so a stale request cannot hang
                            op_q <= OP_RELEASE;
                            wval_q <= 1'b1;
                            st_q <= S_WR;
                        end else begin
                            st_q <= S_DONE;
                        end
                    end
                end
                S_WAIT: begin
                    // idle gap between polls guarantees a fresh latch
                    token_select_n_q <= 1'b1;
                    out_en_n_q <= 1'b1;
                    st_q <= S_RD;
                end
                S_DONE: begin
                    if (init_q) begin
                        if (idx_q == `TKS_NUM_TOKENS - 1) begin
                            init_q <= 1'b0;
                            init_done_q <= 1'b1;
                            cmd_ready_q <= 1'b1;
                            st_q <= S_IDLE;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            st_q <= S_INIT;
                        end
                    end else begin
                        // withdrawn claim ends ungranted; release ends ungranted
                        if (op_q == OP_RELEASE) begin
                            granted_q <= 1'b0;
                        end
                        done_q <= 1'b1;
                        cmd_ready_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // copy held map to an output flop
    always @(posedge core_clk) begin
        if (!nrst) begin
            held_q <= {`TKS_NUM_TOKENS{1'b0}};
        end else begin
            held_q <= held_w;
        end
    end
endmodule // tks_port_ctrl
